// *** rtl/fprt_pkg.sv ***
package fprt_pkg;

  // Register offsets
  localparam logic [7:0]  FPRT_TX_PTR_OFS  = 8'h84;
  localparam logic [7:0]  FPRT_RX_PTR_OFS  = 8'h86;
  localparam logic [7:0]  FPRT_DUR_OFS     = 8'h8c;
  localparam logic [7:0]  FPRT_BYTE_OFS    = 8'h8e;

  // Field positions and pointer width
  localparam int          FPRT_AUTO_BIT    = 14;
  localparam int          FPRT_WSS_BIT     = 12;
  localparam int          FPRT_BOS_BIT     = 11;
  localparam int          FPRT_PTR_W       = 11;

  // Reset values and limits
  localparam logic [10:0] FPRT_PTR_RST     = 11'h000;
  localparam logic [15:0] FPRT_THR_RST     = 16'h0000;
  localparam logic [15:0] FPRT_DUR_MAX     = 16'hcfff;

  // Timing
  localparam int          FPRT_CLK_NS      = 50;
  localparam int          FPRT_TICK_NS     = 1000;
  localparam int          FPRT_TICK_CYC    = (FPRT_TICK_NS + FPRT_CLK_NS - 1) / FPRT_CLK_NS;
  localparam int          FPRT_DIV_W       = 5;

  typedef enum logic [1:0] {
    FPRT_SZ_BYTE  = 2'h0,
    FPRT_SZ_WORD  = 2'h1,
    FPRT_SZ_DWORD = 2'h2
  } fprt_size_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [1:0]  be;
    logic [15:0] wdata;
  } fprt_bus_t;

  typedef struct packed {
    logic                  tx_auto;
    logic [10:0]           tx_ptr;
    logic                  rx_auto;
    logic [10:0]           rx_ptr;
    logic                  wss;
    logic                  bos;
    logic [15:0]           dur_lim;
    logic [15:0]           byte_lim;
    logic [FPRT_DIV_W-1:0] div;
    logic [15:0]           dur_us;
    logic                  flag;
    logic                  dur_pend;
    logic                  byte_pend;
    logic                  dur_cause;
    logic                  byte_cause;
    logic [15:0]           rdata;
  } fprt_state_t;

  function automatic logic [10:0] fprt_step(input fprt_size_t sz);
    unique case (sz)
      FPRT_SZ_BYTE:  fprt_step = 11'h001;
      FPRT_SZ_WORD:  fprt_step = 11'h002;
      FPRT_SZ_DWORD: fprt_step = 11'h004;
      default:       fprt_step = 11'h000;
    endcase
  endfunction

  function automatic logic [15:0] fprt_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  be);
    fprt_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

endpackage

// *** rtl/fprt_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module fprt_regs
  import fprt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire fprt_bus_t   bus,
  input  wire logic        dma_active,
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire fprt_size_t  data_size,
  input  wire logic        txq_enqueue,
  input  wire logic [10:0] tx_next_free,
  input  wire logic        dur_thr_en,
  input  wire logic        byte_thr_en,
  input  wire logic        rx_frame_present,
  input  wire logic [15:0] rx_byte_count,
  input  wire logic        rx_event_clear,
  output logic [15:0]      rd_data,
  output logic [10:0]      tx_location_index,
  output logic [10:0]      rx_location_index,
  output logic             tx_pointer_auto_advance,
  output logic             rx_pointer_auto_advance,
  output logic             write_sample_select,
  output logic             byte_order_select,
  output logic             rx_event_flag,
  output logic             dur_cause,
  output logic             byte_cause
);

  fprt_state_t state_reg;
  fprt_state_t state_next;

  logic        reg_wr;
  logic        reg_rd;
  logic        wr_tx;
  logic        wr_rx;
  logic        wr_dur;
  logic        wr_byte;
  logic [15:0] tx_image;
  logic [15:0] rx_image;
  logic [15:0] rx_store;
  logic [15:0] tx_new;
  logic [15:0] rx_new;
  logic [15:0] dur_new;
  logic [15:0] byte_new;
  logic [10:0] step;
  logic        tick;
  logic        dur_hit;
  logic        byte_hit;

  // No register is reachable during a buffer burst, so all writes and reads are locked
  assign reg_wr  = bus.wr && !dma_active;
  assign reg_rd  = bus.rd && !dma_active;
  assign wr_tx   = reg_wr && (bus.addr == FPRT_TX_PTR_OFS);
  assign wr_rx   = reg_wr && (bus.addr == FPRT_RX_PTR_OFS);
  assign wr_dur  = reg_wr && (bus.addr == FPRT_DUR_OFS);
  assign wr_byte = reg_wr && (bus.addr == FPRT_BYTE_OFS);

  always_comb begin
    tx_image = 16'h0000;
    tx_image[FPRT_AUTO_BIT] = state_reg.tx_auto;
    tx_image[FPRT_PTR_W-1:0] = state_reg.tx_ptr;
    rx_image = 16'h0000;
    rx_image[FPRT_AUTO_BIT] = state_reg.rx_auto;
    rx_image[FPRT_WSS_BIT] = state_reg.wss;
    rx_image[FPRT_PTR_W-1:0] = state_reg.rx_ptr;
    rx_store = rx_image;
    rx_store[FPRT_BOS_BIT] = state_reg.bos;
  end

  assign tx_new   = fprt_merge(tx_image, bus.wdata, bus.be);
  assign rx_new   = fprt_merge(rx_store, bus.wdata, bus.be);
  assign dur_new  = fprt_merge(state_reg.dur_lim, bus.wdata, bus.be);
  assign byte_new = fprt_merge(state_reg.byte_lim, bus.wdata, bus.be);
  assign step     = fprt_step(data_size);

  assign tick     = (state_reg.div == FPRT_DIV_W'(FPRT_TICK_CYC - 1));
  // Timer only runs while a frame waits; it restarts when the buffer empties
  assign dur_hit  = dur_thr_en && rx_frame_present && (state_reg.dur_us > state_reg.dur_lim);
  assign byte_hit = byte_thr_en && (rx_byte_count > state_reg.byte_lim);

  always_comb begin
    state_next = state_reg;

    // Transmit pointer: enqueue reload, then host write, then auto step
    if (txq_enqueue) begin
      state_next.tx_ptr = tx_next_free;
    end else if (wr_tx) begin
      state_next.tx_ptr = tx_new[FPRT_PTR_W-1:0];
    end else if (data_wr && state_reg.tx_auto) begin
      state_next.tx_ptr = state_reg.tx_ptr + step;
    end
    if (wr_tx) begin
      state_next.tx_auto = tx_new[FPRT_AUTO_BIT];
    end

    // Receive pointer: host may zero it before a read burst
    if (wr_rx) begin
      state_next.rx_ptr = rx_new[FPRT_PTR_W-1:0];
      state_next.rx_auto = rx_new[FPRT_AUTO_BIT];
      state_next.wss = rx_new[FPRT_WSS_BIT];
      state_next.bos = rx_new[FPRT_BOS_BIT];
    end else if (data_rd && state_reg.rx_auto) begin
      state_next.rx_ptr = state_reg.rx_ptr + step;
    end

    // Out of range duration limits are clamped rather than stored
    if (wr_dur) begin
      state_next.dur_lim = (dur_new > FPRT_DUR_MAX) ? FPRT_DUR_MAX : dur_new;
    end
    if (wr_byte) begin
      state_next.byte_lim = byte_new;
    end

    // Microsecond base and elapsed time since first frame, saturating
    if (!rx_frame_present) begin
      state_next.div = '0;
      state_next.dur_us = 16'h0000;
    end else if (tick) begin
      state_next.div = '0;
      if (state_reg.dur_us != 16'hffff) begin
        state_next.dur_us = state_reg.dur_us + 16'h0001;
      end
    end else begin
      state_next.div = state_reg.div + FPRT_DIV_W'(1);
    end

    // Event flag: a hit in the clearing cycle keeps it set
    if (rx_event_clear) begin
      state_next.dur_cause = state_reg.dur_pend || dur_hit;
      state_next.byte_cause = state_reg.byte_pend || byte_hit;
      state_next.dur_pend = dur_hit;
      state_next.byte_pend = byte_hit;
      state_next.flag = dur_hit || byte_hit;
    end else begin
      state_next.dur_pend = state_reg.dur_pend || dur_hit;
      state_next.byte_pend = state_reg.byte_pend || byte_hit;
      state_next.flag = state_reg.flag || dur_hit || byte_hit;
    end

    // Read data holds until the next register read
    if (reg_rd) begin
      unique case (bus.addr)
        FPRT_TX_PTR_OFS: state_next.rdata = tx_image;
        FPRT_RX_PTR_OFS: state_next.rdata = rx_image;
        FPRT_DUR_OFS:    state_next.rdata = state_reg.dur_lim;
        FPRT_BYTE_OFS:   state_next.rdata = state_reg.byte_lim;
        default:         state_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.tx_ptr <= FPRT_PTR_RST;
      state_reg.rx_ptr <= FPRT_PTR_RST;
      state_reg.dur_lim <= FPRT_THR_RST;
      state_reg.byte_lim <= FPRT_THR_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data                 = state_reg.rdata;
  assign tx_location_index       = state_reg.tx_ptr;
  assign rx_location_index       = state_reg.rx_ptr;
  assign tx_pointer_auto_advance = state_reg.tx_auto;
  assign rx_pointer_auto_advance = state_reg.rx_auto;
  assign write_sample_select     = state_reg.wss;
  assign byte_order_select       = state_reg.bos;
  assign rx_event_flag           = state_reg.flag;
  assign dur_cause               = state_reg.dur_cause;
  assign byte_cause              = state_reg.byte_cause;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_tx_advance;
    (data_wr && state_reg.tx_auto && !txq_enqueue && !wr_tx)
      |=> (tx_location_index == 11'($past(tx_location_index) + $past(step)));
  endproperty
  a_tx_advance: assert property (p_tx_advance) else $error("tx pointer did not step");

  property p_step_dword;
    (data_rd && state_reg.rx_auto && !wr_rx && data_size == FPRT_SZ_DWORD)
      |=> (rx_location_index == 11'($past(rx_location_index) + 11'h004));
  endproperty
  a_step_dword: assert property (p_step_dword) else $error("dword step not four");

  property p_tx_hold;
    (!state_reg.tx_auto && !txq_enqueue && !wr_tx) |=> $stable(tx_location_index);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx pointer moved without cause");

  property p_enqueue;
    txq_enqueue |=> (tx_location_index == $past(tx_next_free));
  endproperty
  a_enqueue: assert property (p_enqueue) else $error("enqueue did not reload");

  property p_rx_hold;
    (!state_reg.rx_auto && !wr_rx) |=> $stable(rx_location_index);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx pointer moved without cause");

  property p_rx_readback;
    (reg_rd && bus.addr == FPRT_RX_PTR_OFS)
      |=> (!rd_data[FPRT_BOS_BIT] && rd_data[FPRT_WSS_BIT] == $past(write_sample_select)
           && rd_data[FPRT_PTR_W-1:0] == $past(rx_location_index));
  endproperty
  a_rx_readback: assert property (p_rx_readback) else $error("rx readback wrong");

  property p_dur_cap;
    wr_dur |=> (state_reg.dur_lim <= FPRT_DUR_MAX);
  endproperty
  a_dur_cap: assert property (p_dur_cap) else $error("duration limit above cap");

  property p_dur_event;
    dur_hit |=> rx_event_flag;
  endproperty
  a_dur_event: assert property (p_dur_event) else $error("duration hit lost");

  property p_byte_event;
    byte_hit |=> rx_event_flag;
  endproperty
  a_byte_event: assert property (p_byte_event) else $error("byte hit lost");

  property p_cause;
    rx_event_clear |=> (dur_cause == ($past(state_reg.dur_pend) || $past(dur_hit))
                        && byte_cause == ($past(state_reg.byte_pend) || $past(byte_hit)));
  endproperty
  a_cause: assert property (p_cause) else $error("cause bits not updated");

  property p_sticky;
    (rx_event_flag && !rx_event_clear) |=> rx_event_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("event flag dropped");

  property p_locked;
    (dma_active && bus.wr) |=> ($stable(state_reg.dur_lim) && $stable(state_reg.byte_lim));
  endproperty
  a_locked: assert property (p_locked) else $error("write accepted during burst");

  property p_rx_advance;
    (data_rd && state_reg.rx_auto && !wr_rx)
      |=> (rx_location_index == 11'($past(rx_location_index) + $past(step)));
  endproperty
  a_rx_advance: assert property (p_rx_advance) else $error("rx pointer did not step");

  property p_flag_clear;
    (rx_event_clear && !dur_hit && !byte_hit) |=> !rx_event_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("event flag not cleared");

  property p_tx_write;
    (wr_tx && !txq_enqueue) |=> (tx_location_index == 11'($past(tx_new)));
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx pointer write lost");

  property p_cv_advance;
    data_wr && state_reg.tx_auto ##1 data_wr && state_reg.tx_auto;
  endproperty
  c_cv_advance: cover property (p_cv_advance);

  property p_cv_dur;
    !rx_event_flag ##1 rx_event_flag && dur_thr_en;
  endproperty
  c_cv_dur: cover property (p_cv_dur);

  property p_cv_clear;
    rx_event_flag && rx_event_clear ##1 !rx_event_flag;
  endproperty
  c_cv_clear: cover property (p_cv_clear);

  property p_cv_wrap;
    data_rd && state_reg.rx_auto && rx_location_index == 11'h7ff;
  endproperty
  c_cv_wrap: cover property (p_cv_wrap);

  property p_cv_locked;
    dma_active && bus.wr;
  endproperty
  c_cv_locked: cover property (p_cv_locked);

endmodule // fprt_regs
`default_nettype wire

// *** verification/fprt_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module fprt_host
  import fprt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  output fprt_bus_t        bus
);
  initial bus = '0;
  // Request stands for exactly the one taking edge, then the bus is scrambled
  task automatic access(input logic [7:0] a, input logic w, input logic [15:0] d,
                        output logic [15:0] q);
    bus <= '{addr: a, wr: w, rd: !w, be: 2'h3, wdata: d};
    @(posedge clk);
    bus <= '{addr: ~a, wr: 1'b0, rd: 1'b0, be: 2'h0, wdata: ~d};
    @(posedge clk);
    q = rd_data;
  endtask
endmodule // fprt_host
`default_nettype wire

// *** verification/test_fprt_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_fprt_regs;
  import fprt_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  fprt_bus_t   bus;
  logic        dma_active = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
  fprt_size_t  data_size = FPRT_SZ_BYTE;
  logic        txq_enqueue = 1'b0, dur_thr_en = 1'b0, byte_thr_en = 1'b0;
  logic [10:0] tx_next_free = 11'h000;
  logic        rx_frame_present = 1'b0, rx_event_clear = 1'b0;
  logic [15:0] rx_byte_count = 16'h0000, rd_data, q;
  logic [10:0] tx_location_index, rx_location_index;
  logic        tx_pointer_auto_advance, rx_pointer_auto_advance, write_sample_select;
  logic        byte_order_select, rx_event_flag, dur_cause, byte_cause;
  int          err_total = 0, checks_done = 0;

  fprt_host HOST (.clk(clk), .rd_data(rd_data), .bus(bus));
  fprt_regs DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .dma_active(dma_active),
    .data_wr(data_wr), .data_rd(data_rd), .data_size(data_size), .txq_enqueue(txq_enqueue),
    .tx_next_free(tx_next_free), .dur_thr_en(dur_thr_en), .byte_thr_en(byte_thr_en),
    .rx_frame_present(rx_frame_present), .rx_byte_count(rx_byte_count),
    .rx_event_clear(rx_event_clear), .rd_data(rd_data), .tx_location_index(tx_location_index),
    .rx_location_index(rx_location_index), .tx_pointer_auto_advance(tx_pointer_auto_advance),
    .rx_pointer_auto_advance(rx_pointer_auto_advance),
    .write_sample_select(write_sample_select), .byte_order_select(byte_order_select),
    .rx_event_flag(rx_event_flag), .dur_cause(dur_cause), .byte_cause(byte_cause));

  initial forever #25 clk = ~clk;

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic strobe(input logic rx, input fprt_size_t sz);
    data_size <= sz;
    data_wr   <= !rx;
    data_rd   <= rx;
    @(posedge clk);
    data_wr <= 1'b0;
    data_rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset_map();
    check("pins reset", 16'({tx_pointer_auto_advance, rx_pointer_auto_advance,
      write_sample_select, byte_order_select, rx_event_flag, dur_cause, byte_cause}),
      16'h0000);
    HOST.access(FPRT_TX_PTR_OFS, 1'b0, 16'h0, q); check("tx reset", q, 16'h0000);
    HOST.access(FPRT_RX_PTR_OFS, 1'b0, 16'h0, q); check("rx reset", q, 16'h0000);
    HOST.access(FPRT_DUR_OFS, 1'b0, 16'h0, q);    check("dur reset", q, 16'h0000);
    HOST.access(FPRT_BYTE_OFS, 1'b0, 16'h0, q);   check("byte reset", q, 16'h0000);
    HOST.access(8'h88, 1'b0, 16'h0, q);           check("unmapped", q, 16'h0000);
    $display("test reset_map done");
  endtask

  task automatic t_tx_pointer();
    logic [10:0] exp;
    HOST.access(FPRT_TX_PTR_OFS, 1'b1, 16'hf805, q);
    HOST.access(FPRT_TX_PTR_OFS, 1'b0, 16'h0, q); check("tx image", q, 16'h4005);
    check("tx auto", 16'(tx_pointer_auto_advance), 16'h0001);
    exp = 11'h005;
    for (int s = 0; s < 3; s++) begin
      strobe(1'b0, fprt_size_t'(s));
      exp = exp + (11'h001 << s);
      check("tx step", 16'(tx_location_index), 16'(exp));
    end
    HOST.access(FPRT_TX_PTR_OFS, 1'b1, 16'h47ff, q);
    strobe(1'b0, FPRT_SZ_WORD); check("tx wrap", 16'(tx_location_index), 16'h0001);
    tx_next_free <= 11'h123;
    txq_enqueue  <= 1'b1;
    @(posedge clk);
    txq_enqueue <= 1'b0;
    @(posedge clk);
    check("tx reload", 16'(tx_location_index), 16'h0123);
    HOST.access(FPRT_TX_PTR_OFS, 1'b1, 16'h0000, q);
    strobe(1'b0, FPRT_SZ_DWORD); check("tx manual", 16'(tx_location_index), 16'h0000);
    $display("test tx_pointer done");
  endtask

  task automatic t_rx_pointer();
    HOST.access(FPRT_RX_PTR_OFS, 1'b1, 16'hfffe, q);
    HOST.access(FPRT_RX_PTR_OFS, 1'b0, 16'h0, q); check("rx image", q, 16'h57fe);
    check("rx auto", 16'(rx_pointer_auto_advance), 16'h0001);
    check("sample sel", 16'(write_sample_select), 16'h0001);
    check("order sel", 16'(byte_order_select), 16'h0001);
    strobe(1'b1, FPRT_SZ_DWORD); check("rx wrap", 16'(rx_location_index), 16'h0002);
    HOST.access(FPRT_RX_PTR_OFS, 1'b1, 16'h0000, q);
    check("sample clr", 16'(write_sample_select), 16'h0000);
    strobe(1'b1, FPRT_SZ_WORD); check("rx manual", 16'(rx_location_index), 16'h0000);
    $display("test rx_pointer done");
  endtask

  task automatic t_thresholds();
    HOST.access(FPRT_DUR_OFS, 1'b1, 16'hd000, q);
    HOST.access(FPRT_DUR_OFS, 1'b0, 16'h0, q); check("dur clamp", q, FPRT_DUR_MAX);
    HOST.access(FPRT_BYTE_OFS, 1'b1, 16'h0010, q);
    dma_active <= 1'b1;
    HOST.access(FPRT_BYTE_OFS, 1'b1, 16'hbeef, q);
    dma_active <= 1'b0;
    HOST.access(FPRT_BYTE_OFS, 1'b0, 16'h0, q); check("locked wr", q, 16'h0010);
    rx_byte_count <= 16'h0010;
    byte_thr_en   <= 1'b1;
    repeat (3) @(posedge clk);
    check("byte equal", 16'(rx_event_flag), 16'h0000);
    rx_byte_count <= 16'h0011;
    repeat (2) @(posedge clk);
    rx_byte_count <= 16'h0000;
    HOST.access(FPRT_BYTE_OFS, 1'b0, 16'h0, q);
    check("byte over", 16'(rx_event_flag), 16'h0001);
    rx_event_clear <= 1'b1;
    @(posedge clk);
    rx_event_clear <= 1'b0;
    @(posedge clk);
    check("flag clr", 16'(rx_event_flag), 16'h0000);
    check("cause b", {dur_cause, byte_cause}, 16'h0001);
    $display("test thresholds done");
  endtask

  task automatic t_duration();
    int n;
    byte_thr_en <= 1'b0;
    HOST.access(FPRT_DUR_OFS, 1'b1, 16'h0002, q);
    dur_thr_en       <= 1'b1;
    rx_frame_present <= 1'b1;
    repeat (45) @(posedge clk);
    check("dur early", 16'(rx_event_flag), 16'h0000);
    n = 0;
    while (rx_event_flag !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    if (n == 30) begin
      err_total++;
      stop_test();
    end
    check("dur hit", 16'(rx_event_flag), 16'h0001);
    rx_frame_present <= 1'b0;
    dur_thr_en       <= 1'b0;
    @(posedge clk);
    rx_event_clear <= 1'b1;
    @(posedge clk);
    rx_event_clear <= 1'b0;
    @(posedge clk);
    check("cause d", {dur_cause, byte_cause}, 16'h0002);
    $display("test duration done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_map();
    t_tx_pointer();
    t_rx_pointer();
    t_thresholds();
    t_duration();
    stop_test();
  end
endmodule // test_fprt_regs
`default_nettype wire
